// [hw/hlscb_pkg.sv]
// Package with the register map and field positions of the accelerator control bank.
package hlscb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Word offsets as byte addresses.
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_GIE      = 8'h04;
    localparam logic [7:0] OFS_IER      = 8'h08;
    localparam logic [7:0] OFS_ISR      = 8'h0c;
    localparam logic [7:0] OFS_ARG_IN   = 8'h10;
    localparam logic [7:0] OFS_ARG_IN_C = 8'h14;
    localparam logic [7:0] OFS_ARG_OUT  = 8'h18;
    localparam logic [7:0] OFS_ARG_OUTC = 8'h1c;
    localparam logic [7:0] OFS_ARR_BASE = 8'h40;
    localparam logic [7:0] OFS_ARR_HIGH = 8'h7c;
    // Array of 8-bit elements packed four to a word.
    localparam int ARR_WORDS = 16;
    localparam int ARR_IDX_W = 4;
    localparam int ELEM_W    = 8;
    localparam int ELEMS     = 64;
    localparam int ELEM_IDX_W = 6;
    // Control register fields.
    localparam int CTRL_START    = 0;
    localparam int CTRL_DONE     = 1;
    localparam int CTRL_IDLE     = 2;
    localparam int CTRL_READY    = 3;
    localparam int CTRL_CONTINUE = 4;
    localparam int CTRL_AUTO     = 7;
    localparam int CTRL_CHAIN    = 8;
    // Interrupt source positions.
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_N     = 2;
    // Argument flag fields.
    localparam int FLG_VLD = 0;
    localparam int FLG_ACK = 1;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// [hw/hlscb_bank.sv]
// Control and status register bank for an accelerator core on an Avalon-MM slave port.
//
// Behaviour
// RULE_01: Software start command raises the block go request toward the core.
// RULE_02: Completion indication of the core is readable by software.
// RULE_03: Core quiet indication is readable as a status bit.
// RULE_04: Core accepts-input indication is readable as a status bit.
// RULE_05: Software proceed command raises the proceed signal toward the core.
// RULE_06: Auto-restart bit starts the next run on completion; clearing it stops that.
// RULE_07: Writable location drives the scalar input argument port.
// RULE_08: Software can raise the input argument valid flag.
// RULE_09: Software can raise the output argument acknowledge flag.
// RULE_10: Readable location returns the scalar output argument port value.
// RULE_11: Output argument valid flag is readable by software.
// RULE_12: Input argument acknowledge flag is readable by software.
// RULE_13: Array occupies a contiguous range from base to uppermost element address.
// RULE_14: Narrow array elements are packed four to one 32-bit word.
// RULE_15: Wide elements span consecutive words; not used by this 8-bit array.
// RULE_16: Global enable gates the interrupt output.
// RULE_17: Two interrupt sources, completion and ready, each individually enabled.
// RULE_18: Enabled interrupt sources read back from the enable register.
// RULE_19: Triggered sources latch in a readable status register.
// RULE_20: Writing one to a status bit clears it.
// RULE_21: With auto-restart, start is raised again when completion arrives.
// RULE_22: Chained mode restarts on ready if proceed was given at completion. Here auto-restart set at completion also counts, so proceed is not needed.
// RULE_23: Interrupt rises when global enable and any enabled latched source are set.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hlscb_bank (
    // Clock and reset
    input  wire logic                      CLK_SYS,
    input  wire logic                      SRST,
    // Avalon-MM slave
    input  wire logic [hlscb_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input  wire logic                      AVS_READ,
    input  wire logic                      AVS_WRITE,
    input  wire logic [3:0]                AVS_BYTEENABLE,
    input  wire logic [hlscb_pkg::DATA_W-1:0] AVS_WRITEDATA,
    output logic      [hlscb_pkg::DATA_W-1:0] AVS_READDATA,
    output logic                           AVS_WAITREQUEST,
    output logic [1:0]                     AVS_RESPONSE,
    // Block control toward the core and status back from it
    output logic                           BLOCK_GO_REQUEST,
    output logic                           BLOCK_PROCEED_SIGNAL,
    input  wire logic                      BLOCK_FINISHED_FLAG,
    input  wire logic                      BLOCK_QUIET_FLAG,
    input  wire logic                      BLOCK_ACCEPTS_INPUT_FLAG,
    // Scalar input argument
    output logic [hlscb_pkg::DATA_W-1:0]   SCALAR_ARGUMENT_PORT_IN,
    output logic                           ARGUMENT_VALID_FLAG_IN,
    input  wire logic                      ARGUMENT_ACKNOWLEDGE_FLAG_IN,
    // Scalar output argument
    input  wire logic [hlscb_pkg::DATA_W-1:0] SCALAR_ARGUMENT_PORT_OUT,
    input  wire logic                      ARGUMENT_VALID_FLAG_OUT,
    output logic                           ARGUMENT_ACKNOWLEDGE_FLAG_OUT,
    // Core side of the array
    input  wire logic [hlscb_pkg::ELEM_IDX_W-1:0] ARRAY_ELEM_INDEX,
    output logic      [hlscb_pkg::ELEM_W-1:0]     ARRAY_ELEM_DATA,
    // Interrupt
    output logic                           IRQ
);
    // Core status and data arrive from the core's own clock domain and are synchronised.
    logic [3:0]  st_s1_r, st_s2_r;
    logic [31:0] ao_s1_r, ao_s2_r;
    logic        fin_d_r;
    always_ff @(posedge CLK_SYS) begin
        st_s1_r <= {ARGUMENT_VALID_FLAG_OUT, BLOCK_ACCEPTS_INPUT_FLAG,
                    BLOCK_QUIET_FLAG, BLOCK_FINISHED_FLAG};
        st_s2_r <= st_s1_r;
        ao_s1_r <= SCALAR_ARGUMENT_PORT_OUT;
        ao_s2_r <= ao_s1_r;
    end
    logic       ack_s1_r, ack_s2_r;
    always_ff @(posedge CLK_SYS) begin
        ack_s1_r <= ARGUMENT_ACKNOWLEDGE_FLAG_IN;
        ack_s2_r <= ack_s1_r;
    end
    wire        fin  = st_s2_r[0];
    wire        quiet = st_s2_r[1];
    wire        rdy  = st_s2_r[2];
    wire        ovld = st_s2_r[3];
    wire        fin_rise = fin & ~fin_d_r;

    // Bus decode: one wait state on reads, writes answer at once.
    logic       rd_pend_r;
    wire        wr_en   = AVS_WRITE & ~AVS_READ;
    wire        rd_done = AVS_READ & rd_pend_r;
    wire [7:0]  a       = AVS_ADDRESS;
    wire        hit_ctrl  = (a == hlscb_pkg::OFS_CTRL);
    wire        hit_gie   = (a == hlscb_pkg::OFS_GIE);
    wire        hit_ier   = (a == hlscb_pkg::OFS_IER);
    wire        hit_isr   = (a == hlscb_pkg::OFS_ISR);
    wire        hit_ain   = (a == hlscb_pkg::OFS_ARG_IN);
    wire        hit_ainc  = (a == hlscb_pkg::OFS_ARG_IN_C);
    wire        hit_aout  = (a == hlscb_pkg::OFS_ARG_OUT);
    wire        hit_aoutc = (a == hlscb_pkg::OFS_ARG_OUTC);
    // RULE_13: contiguous array range
    wire        hit_arr = (a >= hlscb_pkg::OFS_ARR_BASE) && (a <= hlscb_pkg::OFS_ARR_HIGH)
                          && (a[1:0] == 2'b00);
    wire [hlscb_pkg::ARR_IDX_W-1:0] arr_idx = a[5:2];
    wire        mapped = hit_ctrl | hit_gie | hit_ier | hit_isr | hit_ain | hit_ainc
                         | hit_aout | hit_aoutc | hit_arr;
    wire        be0 = AVS_BYTEENABLE[0];
    wire        be1 = AVS_BYTEENABLE[1];

    // Control state.
    logic        go_r, proceed_r, auto_r, chain_r, done_lat_r, cont_at_done_r;
    logic        gie_r, irq_r;
    logic [1:0]  ier_r, isr_r;
    logic [31:0] ain_r;
    logic        ivld_r, oack_r;
    logic [31:0] rdata_r;
    logic [1:0]  resp_r;
    logic [31:0] arr_mem [hlscb_pkg::ARR_WORDS];
    logic [7:0]  elem_r;

    wire wr_ctrl = wr_en & hit_ctrl & be0;
    wire sw_start = wr_ctrl & AVS_WRITEDATA[hlscb_pkg::CTRL_START];
    wire sw_cont  = wr_ctrl & AVS_WRITEDATA[hlscb_pkg::CTRL_CONTINUE];
    // RULE_21: plain auto-restart on completion
    wire auto_plain = auto_r & ~chain_r & fin_rise;
    // RULE_22: chained restart needs proceed or auto-restart set at completion, then ready
    wire auto_chain = auto_r & chain_r & rdy & cont_at_done_r;
    // RULE_06: auto-restart request
    wire auto_go  = auto_plain | auto_chain;
    wire go_nxt   = (go_r | sw_start | auto_go) & ~(go_r & rdy & ~sw_start & ~auto_go);
    // RULE_17: two sources
    wire [1:0] src_ev = {rdy, fin_rise};
    wire [1:0] isr_clr = (wr_en & hit_isr & be0) ? AVS_WRITEDATA[1:0] : 2'b00;
    // RULE_20: set wins over clear
    wire [1:0] isr_nxt = (isr_r & ~isr_clr) | src_ev;
    // RULE_23: gated interrupt
    wire       irq_nxt = gie_r & |(ier_r & isr_nxt);

    // RULE_02: completion latched until read
    wire ctrl_rd = rd_done & hit_ctrl;
    wire done_nxt = fin_rise | (done_lat_r & ~ctrl_rd);

    wire [31:0] ctrl_v = {23'h000000, chain_r, auto_r, 2'b00, proceed_r, rdy, quiet,
                          done_lat_r, go_r};
    wire [31:0] ainc_v = {30'h00000000, ack_s2_r, ivld_r};
    wire [31:0] aoutc_v = {30'h00000000, oack_r, ovld};
    wire [31:0] rd_mux =
        hit_ctrl  ? ctrl_v :                          // RULE_03 RULE_04 status bits
        hit_gie   ? {31'h00000000, gie_r} :
        hit_ier   ? {30'h00000000, ier_r} :           // RULE_18 enabled sources
        hit_isr   ? {30'h00000000, isr_r} :           // RULE_19 latched sources
        hit_ain   ? ain_r :
        hit_ainc  ? ainc_v :                          // RULE_12 input ack readable
        hit_aout  ? ao_s2_r :                         // RULE_10 output value
        hit_aoutc ? aoutc_v :                         // RULE_11 output valid readable
        hit_arr   ? arr_mem[arr_idx] : hlscb_pkg::READ_ZERO;

    // RULE_15: no wide elements
    // Every element fits in one byte lane, so none ever spans two words.
    // RULE_14: four 8-bit elements per word, element 0 in the low byte
    wire [31:0] elem_word = arr_mem[ARRAY_ELEM_INDEX[5:2]];
    wire [7:0]  elem_sel  = elem_word[8*ARRAY_ELEM_INDEX[1:0] +: 8];

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rd_pend_r <= 1'b0;
            fin_d_r   <= 1'b0;
        end else begin
            rd_pend_r <= AVS_READ & ~rd_pend_r;
            fin_d_r   <= fin;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            go_r <= 1'b0;
            proceed_r <= 1'b0;
            auto_r <= 1'b0;
            chain_r <= 1'b0;
            done_lat_r <= 1'b0;
            cont_at_done_r <= 1'b0;
        end else begin
            // RULE_01: go held until core is ready
            go_r <= go_nxt;
            // RULE_05: proceed pulse
            proceed_r <= sw_cont | (auto_r & chain_r & fin_rise);
            if (wr_ctrl) begin
                auto_r  <= AVS_WRITEDATA[hlscb_pkg::CTRL_AUTO];
                chain_r <= AVS_WRITEDATA[hlscb_pkg::CTRL_CHAIN];
            end
            done_lat_r <= done_nxt;
            if (fin_rise)
                cont_at_done_r <= proceed_r | sw_cont | auto_r;
            else if (auto_chain)
                cont_at_done_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            gie_r <= 1'b0;
            ier_r <= 2'b00;
            isr_r <= 2'b00;
            irq_r <= 1'b0;
        end else begin
            // RULE_16: global enable
            if (wr_en & hit_gie & be0)
                gie_r <= AVS_WRITEDATA[0];
            if (wr_en & hit_ier & be0)
                ier_r <= AVS_WRITEDATA[hlscb_pkg::IRQ_N-1:0];
            isr_r <= isr_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ain_r  <= 32'h0000_0000;
            ivld_r <= 1'b0;
            oack_r <= 1'b0;
        end else begin
            // RULE_07: input argument value
            if (wr_en & hit_ain) begin
                for (int i = 0; i < 4; i++)
                    if (AVS_BYTEENABLE[i])
                        ain_r[8*i +: 8] <= AVS_WRITEDATA[8*i +: 8];
            end
            // RULE_08: valid held until core acknowledges
            if (wr_en & hit_ainc & be0 & AVS_WRITEDATA[hlscb_pkg::FLG_VLD])
                ivld_r <= 1'b1;
            else if (ack_s2_r)
                ivld_r <= 1'b0;
            // RULE_09: acknowledge is a one-cycle pulse
            oack_r <= wr_en & hit_aoutc & be0 & AVS_WRITEDATA[hlscb_pkg::FLG_ACK];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (wr_en & hit_arr) begin
            for (int i = 0; i < 4; i++)
                if (AVS_BYTEENABLE[i])
                    arr_mem[arr_idx][8*i +: 8] <= AVS_WRITEDATA[8*i +: 8];
        end
    end

    // The element output is cleared by reset; the array is not, so its old contents show again one cycle after reset ends.
    always_ff @(posedge CLK_SYS) begin
        if (SRST)
            elem_r <= 8'h00;
        else
            elem_r <= elem_sel;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            rdata_r <= 32'h0000_0000;
            resp_r  <= 2'b00;
        end else begin
            rdata_r <= rd_mux;
            resp_r  <= mapped ? 2'b00 : 2'b11;
        end
    end

    assign AVS_READDATA         = rdata_r;
    assign AVS_WAITREQUEST      = AVS_READ & ~rd_pend_r;
    assign AVS_RESPONSE         = resp_r;
    assign BLOCK_GO_REQUEST     = go_r;
    assign BLOCK_PROCEED_SIGNAL = proceed_r;
    assign SCALAR_ARGUMENT_PORT_IN = ain_r;
    assign ARGUMENT_VALID_FLAG_IN  = ivld_r;
    assign ARGUMENT_ACKNOWLEDGE_FLAG_OUT = oack_r;
    assign ARRAY_ELEM_DATA      = elem_r;
    assign IRQ                  = irq_r;
endmodule
`default_nettype wire

// [test/hlscb_bank_assertions.sv]
// Port-level checks on the accelerator control bank.
`timescale 1ns/1ps
`default_nettype none
module hlscb_bank_assertions (
    // Clock and reset
    input wire logic                          CLK_SYS,
    input wire logic                          SRST,
    // Bus
    input wire logic [hlscb_pkg::ADDR_W-1:0]  AVS_ADDRESS,
    input wire logic                          AVS_READ,
    input wire logic                          AVS_WRITE,
    input wire logic [3:0]                    AVS_BYTEENABLE,
    input wire logic [hlscb_pkg::DATA_W-1:0]  AVS_WRITEDATA,
    input wire logic [hlscb_pkg::DATA_W-1:0]  AVS_READDATA,
    input wire logic                          AVS_WAITREQUEST,
    input wire logic [1:0]                    AVS_RESPONSE,
    // Core side
    input wire logic                          BLOCK_GO_REQUEST,
    input wire logic                          BLOCK_PROCEED_SIGNAL,
    input wire logic [hlscb_pkg::DATA_W-1:0]  SCALAR_ARGUMENT_PORT_IN,
    input wire logic                          ARGUMENT_VALID_FLAG_IN,
    input wire logic                          ARGUMENT_ACKNOWLEDGE_FLAG_OUT,
    input wire logic                          IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    wire wr0 = AVS_WRITE && AVS_BYTEENABLE[0];
    wire wr_ctrl = wr0 && AVS_ADDRESS == hlscb_pkg::OFS_CTRL;
    property p_wr_nowait; AVS_WRITE |-> !AVS_WAITREQUEST; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_wait; AVS_READ && !$past(AVS_READ) |-> AVS_WAITREQUEST; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answered at once");
    property p_rd_ans; AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_unmapped;
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[7]
        |-> AVS_READDATA == 32'h0 && AVS_RESPONSE == 2'h3;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
    property p_go; wr_ctrl && AVS_WRITEDATA[0] |=> BLOCK_GO_REQUEST; endproperty
    a_go: assert property (p_go) else $error("go not raised");
    property p_proceed;
        wr_ctrl && AVS_WRITEDATA[4] |=> BLOCK_PROCEED_SIGNAL ##1 !BLOCK_PROCEED_SIGNAL;
    endproperty
    a_proceed: assert property (p_proceed) else $error("proceed pulse wrong");
    property p_arg_in;
        AVS_WRITE && AVS_BYTEENABLE == 4'hf && AVS_ADDRESS == hlscb_pkg::OFS_ARG_IN
        |=> SCALAR_ARGUMENT_PORT_IN == $past(AVS_WRITEDATA);
    endproperty
    a_arg_in: assert property (p_arg_in) else $error("argument not stored");
    property p_vld_in;
        wr0 && AVS_ADDRESS == hlscb_pkg::OFS_ARG_IN_C && AVS_WRITEDATA[0] |=> ARGUMENT_VALID_FLAG_IN;
    endproperty
    a_vld_in: assert property (p_vld_in) else $error("valid not raised");
    property p_ack_out;
        wr0 && AVS_ADDRESS == hlscb_pkg::OFS_ARG_OUTC && AVS_WRITEDATA[1]
        |=> ARGUMENT_ACKNOWLEDGE_FLAG_OUT ##1 !ARGUMENT_ACKNOWLEDGE_FLAG_OUT;
    endproperty
    a_ack_out: assert property (p_ack_out) else $error("ack pulse wrong");
    property p_gie_off;
        wr0 && AVS_ADDRESS == hlscb_pkg::OFS_GIE && !AVS_WRITEDATA[0] |-> ##2 !IRQ;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("irq not gated");
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
    c_irq: cover property ($rose(IRQ));
    c_go: cover property ($rose(BLOCK_GO_REQUEST));
endmodule
`default_nettype wire

// [test/hlscb_core_model.sv]
// Behavioural accelerator core that answers the control bank.
`timescale 1ns/1ps
`default_nettype none
module hlscb_core_model (
    // Clock and reset
    input wire logic    clk,
    input wire logic    srst,
    // From the bank
    input wire logic    go,
    input wire logic    vld_in,
    input wire logic    ack_out,
    // To the bank
    output logic        finished,
    output logic        accepts,
    output logic        ack_in,
    output logic        vld_out,
    output logic [31:0] result,
    output wire logic   quiet
);
    logic [3:0] cnt_r;
    logic       busy_r;
    assign quiet = !busy_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            {busy_r, cnt_r, finished, accepts, ack_in, vld_out, result} <= '0;
        end else begin
            finished <= busy_r && cnt_r == 4'h8;
            accepts <= busy_r && cnt_r == 4'h4;
            // Input ack stays up once seen so software can read it late.
            if (vld_in) ack_in <= 1'b1;
            if (busy_r && cnt_r == 4'h8) begin
                busy_r <= 1'b0;
                vld_out <= 1'b1;
                result <= result + 32'h1;
            end else if (busy_r) cnt_r <= cnt_r + 4'h1;
            else if (go) {busy_r, cnt_r} <= 5'h10;
            if (ack_out) vld_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [test/hlscb_bank_tb.sv]
// Self-checking bench for the accelerator control bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module hlscb_bank_tb;
    logic CLK_SYS = 0, SRST = 1, AVS_READ = 0, AVS_WRITE = 0, AVS_WAITREQUEST, IRQ;
    logic [7:0] AVS_ADDRESS = 0, ARRAY_ELEM_DATA;
    logic [5:0] ARRAY_ELEM_INDEX = 0;
    logic [3:0] AVS_BYTEENABLE = 4'hf;
    logic [1:0] AVS_RESPONSE;
    logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
    logic [31:0] SCALAR_ARGUMENT_PORT_IN, SCALAR_ARGUMENT_PORT_OUT;
    logic BLOCK_GO_REQUEST, BLOCK_PROCEED_SIGNAL, BLOCK_FINISHED_FLAG, BLOCK_QUIET_FLAG;
    logic BLOCK_ACCEPTS_INPUT_FLAG, ARGUMENT_VALID_FLAG_IN, ARGUMENT_ACKNOWLEDGE_FLAG_IN;
    logic ARGUMENT_VALID_FLAG_OUT, ARGUMENT_ACKNOWLEDGE_FLAG_OUT;
    int n_mismatch = 0, checks = 0;
    always #10 CLK_SYS = ~CLK_SYS;
    hlscb_bank hlscb_bank_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
        .BLOCK_GO_REQUEST(BLOCK_GO_REQUEST), .BLOCK_PROCEED_SIGNAL(BLOCK_PROCEED_SIGNAL),
        .BLOCK_FINISHED_FLAG(BLOCK_FINISHED_FLAG), .BLOCK_QUIET_FLAG(BLOCK_QUIET_FLAG),
        .BLOCK_ACCEPTS_INPUT_FLAG(BLOCK_ACCEPTS_INPUT_FLAG),
        .SCALAR_ARGUMENT_PORT_IN(SCALAR_ARGUMENT_PORT_IN),
        .ARGUMENT_VALID_FLAG_IN(ARGUMENT_VALID_FLAG_IN),
        .ARGUMENT_ACKNOWLEDGE_FLAG_IN(ARGUMENT_ACKNOWLEDGE_FLAG_IN),
        .SCALAR_ARGUMENT_PORT_OUT(SCALAR_ARGUMENT_PORT_OUT),
        .ARGUMENT_VALID_FLAG_OUT(ARGUMENT_VALID_FLAG_OUT),
        .ARGUMENT_ACKNOWLEDGE_FLAG_OUT(ARGUMENT_ACKNOWLEDGE_FLAG_OUT),
        .ARRAY_ELEM_INDEX(ARRAY_ELEM_INDEX), .ARRAY_ELEM_DATA(ARRAY_ELEM_DATA), .IRQ(IRQ));
    hlscb_core_model hlscb_core_model_i (.clk(CLK_SYS), .srst(SRST), .go(BLOCK_GO_REQUEST),
        .vld_in(ARGUMENT_VALID_FLAG_IN), .ack_out(ARGUMENT_ACKNOWLEDGE_FLAG_OUT),
        .finished(BLOCK_FINISHED_FLAG), .accepts(BLOCK_ACCEPTS_INPUT_FLAG),
        .ack_in(ARGUMENT_ACKNOWLEDGE_FLAG_IN), .vld_out(ARGUMENT_VALID_FLAG_OUT),
        .result(SCALAR_ARGUMENT_PORT_OUT), .quiet(BLOCK_QUIET_FLAG));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, m);
        logic [31:0] q;
        bus(1'b0, a, e, q);
        `CHK(n, e, q & m)
    endtask
    task automatic t_run;
        wr(hlscb_pkg::OFS_IER, 32'h3);
        wr(hlscb_pkg::OFS_GIE, 32'h1);
        wr(hlscb_pkg::OFS_CTRL, 32'h1);
        repeat (30) @(posedge CLK_SYS);
        rd("ctrl", hlscb_pkg::OFS_CTRL, 32'h6, 32'hf);
        rd("done_clr", hlscb_pkg::OFS_CTRL, 32'h0, 32'h2);
        rd("isr", hlscb_pkg::OFS_ISR, 32'h3, 32'h3);
        `CHK("irq", 1'b1, IRQ)
        wr(hlscb_pkg::OFS_ISR, 32'h3);
        rd("isr_clr", hlscb_pkg::OFS_ISR, 32'h0, 32'h3);
        rd("ier", hlscb_pkg::OFS_IER, 32'h3, 32'h3);
        `CHK("irq_off", 1'b0, IRQ)
        wr(hlscb_pkg::OFS_GIE, 32'h0);
    endtask
    task automatic t_args;
        wr(hlscb_pkg::OFS_ARG_IN, 32'h1234_5678);
        // The register loads at the accepting edge, so look one edge later.
        @(posedge CLK_SYS);
        `CHK("arg_in", 32'h1234_5678, SCALAR_ARGUMENT_PORT_IN)
        wr(hlscb_pkg::OFS_ARG_IN_C, 32'h1);
        repeat (8) @(posedge CLK_SYS);
        rd("arg_in_ack", hlscb_pkg::OFS_ARG_IN_C, 32'h2, 32'h3);
        rd("arg_out", hlscb_pkg::OFS_ARG_OUT, 32'h1, 32'hffff_ffff);
        rd("out_vld", hlscb_pkg::OFS_ARG_OUTC, 32'h1, 32'h1);
        wr(hlscb_pkg::OFS_ARG_OUTC, 32'h2);
        wr(hlscb_pkg::OFS_CTRL, 32'h10);
        repeat (4) @(posedge CLK_SYS);
        rd("out_vld_ack", hlscb_pkg::OFS_ARG_OUTC, 32'h0, 32'h1);
    endtask
    task automatic t_array;
        wr(hlscb_pkg::OFS_ARR_BASE, 32'h4433_2211);
        wr(hlscb_pkg::OFS_ARR_HIGH, 32'hddcc_bbaa);
        rd("arr_lo", hlscb_pkg::OFS_ARR_BASE, 32'h4433_2211, 32'hffff_ffff);
        rd("arr_hi", hlscb_pkg::OFS_ARR_HIGH, 32'hddcc_bbaa, 32'hffff_ffff);
        ARRAY_ELEM_INDEX <= 6'h01;
        repeat (2) @(posedge CLK_SYS);
        `CHK("elem1", 8'h22, ARRAY_ELEM_DATA)
        ARRAY_ELEM_INDEX <= 6'h3f;
        repeat (2) @(posedge CLK_SYS);
        `CHK("elem63", 8'hdd, ARRAY_ELEM_DATA)
        rd("unmapped", 8'h80, 32'h0, 32'hffff_ffff);
    endtask
    task automatic t_auto;
        int n;
        logic p;
        n = 0;
        p = 1'b0;
        wr(hlscb_pkg::OFS_CTRL, 32'h81);
        repeat (60) begin
            @(posedge CLK_SYS);
            if (BLOCK_GO_REQUEST && !p) n++;
            p = BLOCK_GO_REQUEST;
        end
        `CHK("restarts", 1'b1, n >= 3)
        wr(hlscb_pkg::OFS_CTRL, 32'h0);
        repeat (40) @(posedge CLK_SYS);
        n = 0;
        repeat (30) @(posedge CLK_SYS) if (BLOCK_GO_REQUEST !== 1'b0) n++;
        `CHK("stopped", 0, n)
        rd("isr_auto", hlscb_pkg::OFS_ISR, 32'h3, 32'h3);
        `CHK("irq_gated", 1'b0, IRQ)
    endtask
    task automatic stop_test;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge CLK_SYS);
        SRST <= 1'b0;
        t_run;
        t_args;
        t_array;
        t_auto;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge CLK_SYS);
        n_mismatch++;
        stop_test;
    end
endmodule
bind hlscb_bank hlscb_bank_assertions hlscb_bank_assertions_i (.CLK_SYS, .SRST, .AVS_ADDRESS,
    .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
    .AVS_RESPONSE, .BLOCK_GO_REQUEST, .BLOCK_PROCEED_SIGNAL, .SCALAR_ARGUMENT_PORT_IN,
    .ARGUMENT_VALID_FLAG_IN, .ARGUMENT_ACKNOWLEDGE_FLAG_OUT, .IRQ);
`default_nettype wire
